// *** rtl/e1cf_pkg.sv ***
// Package of constants for the E1 clock mode and frame format block
package e1cf_pkg;
    // Frame geometry
    localparam int E1CF_FRAME_BITS = 256;
    localparam int E1CF_FRAME_HZ = 8000;
    localparam int E1CF_SLOTS = 32;
    localparam int E1CF_SLOT_BITS = 8;
    localparam logic [4:0] E1CF_TS_ALIGN = 5'h00;
    localparam logic [4:0] E1CF_TS_SIG = 5'h10;
    localparam logic [4:0] E1CF_TS_LAST = 5'h1F;
    localparam logic [2:0] E1CF_BIT_LAST = 3'h7;
    // Alignment word tail, last seven bits of the alignment slot
    localparam logic [6:0] E1CF_FAS_TAIL = 7'h1B;
    // Fixed bit values of the non-alignment word
    localparam logic E1CF_NFAS_BIT2 = 1'h1;
    // Register map
    localparam logic [3:0] E1CF_REG_CTRL = 4'h0;
    localparam logic [3:0] E1CF_REG_JA = 4'h1;
    localparam logic [3:0] E1CF_REG_NAT = 4'h2;
    localparam logic [3:0] E1CF_REG_STAT = 4'h3;
    localparam logic [3:0] E1CF_REG_ID = 4'hF;
    // Control register fields
    localparam int E1CF_CTRL_LINECODE = 5;
    localparam int E1CF_CTRL_RAI = 0;
    localparam int E1CF_CTRL_SI_FAS = 1;
    localparam int E1CF_CTRL_SI_NFAS = 2;
    localparam logic [7:0] E1CF_CTRL_RST = 8'h20;
    // Attenuator register fields
    localparam int E1CF_JA_EN = 0;
    localparam int E1CF_JA_SIDE = 1;
    localparam int E1CF_JA_DEPTH_LSB = 4;
    localparam logic [7:0] E1CF_JA_RST = 8'h70;
    localparam int E1CF_JA_STEP = 16;
    localparam int E1CF_JA_MAX = 128;
    // National bits register: [4:0] value, [7:5] unused
    localparam logic [7:0] E1CF_NAT_RST = 8'h1F;
    // Arbitrary identification value
    localparam logic [7:0] E1CF_ID_VAL = 8'h5A;
    // Clock source selections
    typedef enum logic [1:0] {
        E1CF_SRC_BACKPLANE,
        E1CF_SRC_CLEAN,
        E1CF_SRC_RAW,
        E1CF_SRC_INTERNAL
    } e1cf_src_t;
    // Clock modes
    typedef enum logic [2:0] {
        E1CF_BUS_SYNC_TX_ATTENUATED,
        E1CF_BUS_SYNC_RX_ATTENUATED,
        E1CF_BUS_SYNC_NO_ATTENUATION,
        E1CF_LINE_SYNC,
        E1CF_FREE_RUN
    } e1cf_mode_t;
endpackage

// *** rtl/e1cf_sync.sv ***
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module e1cf_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** rtl/e1cf_hdb3.sv ***
// Line coder: AMI or HDB3 bipolar encoder
`timescale 1ns/1ns
module e1cf_hdb3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_en,
    input wire logic bit_in,
    input wire logic hdb3_en,
    output logic pos_q,
    output logic neg_q
);
    logic [3:0] hist_q;
    logic last_pol_q;
    logic viol_pol_q;
    logic odd_q;
    logic zeros4;
    logic use_b;
    logic pulse;
    logic pol;

    // Current zero after three marks that follow a zero
    assign zeros4 = hdb3_en && !bit_in && (hist_q[2:0] == 3'h0) && hist_q[3];
    // B00V when an even count of marks since last violation
    assign use_b = zeros4 && !odd_q;
    assign pulse = bit_in || zeros4;
    assign pol = zeros4 ? (use_b ? !last_pol_q : last_pol_q) : !last_pol_q;

    // Simplified substitution: violation polarity tracks last mark
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= 4'h0;
            last_pol_q <= 1'b0;
            viol_pol_q <= 1'b0;
            odd_q <= 1'b0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (bit_en) begin
            hist_q <= zeros4 ? 4'hF : {hist_q[2:0] == 3'h0 ? 1'b0 : 1'b1, hist_q[1:0], !bit_in} ^ 4'h0;
            if (pulse) begin
                last_pol_q <= pol;
            end
            if (zeros4) begin
                viol_pol_q <= pol;
                odd_q <= 1'b0;
            end else if (bit_in) begin
                odd_q <= !odd_q;
            end
            pos_q <= pulse && pol;
            neg_q <= pulse && !pol;
        end
    end
endmodule

// *** rtl/e1cf_top.sv ***
// E1 clock mode selection and basic frame builder and aligner
`timescale 1ns/1ns
//
// Functional notes
// - Enabled, side one: attenuator on transmit
// - Enabled, side zero: attenuator on receive
// - Bus mode, disabled: attenuator bypassed entirely
// - Line sync: attenuator on receive, bits ignored
// - Free-run pin low: attenuator disconnected
// - Bus modes: backplane pins inputs, else outputs
// - Mode one: dejitter backplane clock, raw out
// - Mode two: backplane direct, cleaned extract out
// - Mode three: backplane direct, raw out
// - Line sync: cleaned clock drives backplane
// - Free-run: internal clock drives backplane
// - Frames of 256 bits at 8000 Hz
// - Control bit 5 selects HDB3 or AMI
// - 32 slots of 8 bits, MSB first
// - Backplane bit 7 maps to line bit 1
// - Channels 1-30 skip slots 0 and 16
// - Alignment and non-alignment words alternate
// - Receiver searches alignment tail 0011011
// - Spare bits 4-8 carry data link
// - Non-alignment bit three carries remote alarm
// - Alignment bit one: CRC or spare
// - Non-alignment bit one: CRC, E or spare
// - Attenuator depth 16 to 128, steps 16
module e1cf_top
    import e1cf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_or_line_sync_pin,
    input wire logic locked_or_freerun_pin,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic backplane_clock_in,
    input wire logic backplane_frame_pulse_in,
    output logic backplane_clock_out,
    output logic backplane_frame_pulse_out,
    output logic backplane_oe_n,
    input wire logic extracted_clock_in,
    input wire logic clean_clock_in,
    input wire logic internal_clock_in,
    output logic extracted_clock_out,
    output logic [1:0] tx_clock_src,
    output logic ja_on_tx,
    output logic ja_on_rx,
    input wire logic backplane_data_in,
    input wire logic rx_line_data,
    output logic tx_line_pos,
    output logic tx_line_neg,
    output logic link_data_out,
    output logic frame_found
);
    logic bsl_s, bfr_s, bpclk_s, bpfp_s, ext_s, cln_s, int_s, bpd_s, rxd_s;
    logic [7:0] ctrl_q, ja_q, nat_q;
    logic [7:0] rdata_q;
    logic [4:0] slot_q;
    logic [2:0] bit_q;
    logic nfas_q;
    logic [7:0] shift_q;
    logic tx_clk_prev_q, rx_clk_prev_q;
    logic [6:0] rx_hist_q;
    logic found_q;
    logic pos_w, neg_w;
    logic tx_bit_q;
    logic link_q;
    logic [2:0] depth_q;
    e1cf_mode_t mode;
    e1cf_src_t tx_src;
    logic ja_tx, ja_rx, bus_mode;
    logic tx_clk_sel, tx_edge, rx_edge;
    logic [7:0] ts0_word;
    logic line_bit;
    logic payload_slot;
    logic [4:0] chan_num;
    logic [7:0] rd_mux;
    logic [2:0] depth_sel;

    // Pin synchronisers
    e1cf_sync u_s0 (.clk(clk), .rst_n(rst_n), .d(bus_or_line_sync_pin), .q(bsl_s));
    e1cf_sync u_s1 (.clk(clk), .rst_n(rst_n), .d(locked_or_freerun_pin), .q(bfr_s));
    e1cf_sync u_s2 (.clk(clk), .rst_n(rst_n), .d(backplane_clock_in), .q(bpclk_s));
    e1cf_sync u_s3 (.clk(clk), .rst_n(rst_n), .d(backplane_frame_pulse_in), .q(bpfp_s));
    e1cf_sync u_s4 (.clk(clk), .rst_n(rst_n), .d(extracted_clock_in), .q(ext_s));
    e1cf_sync u_s5 (.clk(clk), .rst_n(rst_n), .d(clean_clock_in), .q(cln_s));
    e1cf_sync u_s6 (.clk(clk), .rst_n(rst_n), .d(internal_clock_in), .q(int_s));
    e1cf_sync u_s7 (.clk(clk), .rst_n(rst_n), .d(backplane_data_in), .q(bpd_s));
    e1cf_sync u_s8 (.clk(clk), .rst_n(rst_n), .d(rx_line_data), .q(rxd_s));

    // Mode decode from pins and attenuator bits
    assign mode = !bfr_s ? E1CF_FREE_RUN :
                  !bsl_s ? E1CF_LINE_SYNC :
                  !ja_q[E1CF_JA_EN] ? E1CF_BUS_SYNC_NO_ATTENUATION :
                  ja_q[E1CF_JA_SIDE] ? E1CF_BUS_SYNC_TX_ATTENUATED :
                  E1CF_BUS_SYNC_RX_ATTENUATED;
    assign bus_mode = (mode != E1CF_LINE_SYNC) && (mode != E1CF_FREE_RUN);
    assign ja_tx = (mode == E1CF_BUS_SYNC_TX_ATTENUATED);
    assign ja_rx = (mode == E1CF_BUS_SYNC_RX_ATTENUATED) || (mode == E1CF_LINE_SYNC);
    // Transmit timing source per mode
    assign tx_src = (mode == E1CF_BUS_SYNC_TX_ATTENUATED) ? E1CF_SRC_CLEAN :
                    (mode == E1CF_LINE_SYNC) ? E1CF_SRC_CLEAN :
                    (mode == E1CF_FREE_RUN) ? E1CF_SRC_INTERNAL :
                    E1CF_SRC_BACKPLANE;
    assign tx_clk_sel = (tx_src == E1CF_SRC_CLEAN) ? cln_s :
                        (tx_src == E1CF_SRC_INTERNAL) ? int_s : bpclk_s;
    assign tx_edge = tx_clk_sel && !tx_clk_prev_q;
    assign rx_edge = ext_s && !rx_clk_prev_q;

    // Time slot 0 content: alignment or non-alignment word, bit 1 in [7]
    assign ts0_word = nfas_q ?
        {ctrl_q[E1CF_CTRL_SI_NFAS], E1CF_NFAS_BIT2, ctrl_q[E1CF_CTRL_RAI], nat_q[4:0]} :
        {ctrl_q[E1CF_CTRL_SI_FAS], E1CF_FAS_TAIL};
    assign payload_slot = (slot_q != E1CF_TS_ALIGN) && (slot_q != E1CF_TS_SIG);
    assign chan_num = (slot_q > E1CF_TS_SIG) ? slot_q - 5'h01 : slot_q;
    // Backplane bit 7 arrives first, goes out as line bit 1
    assign line_bit = (slot_q == E1CF_TS_ALIGN) ? ts0_word[E1CF_BIT_LAST - bit_q] : bpd_s;
    assign depth_sel = ja_q[E1CF_JA_DEPTH_LSB +: 3];

    // Clock edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_prev_q <= 1'b0;
            rx_clk_prev_q <= 1'b0;
        end else begin
            tx_clk_prev_q <= tx_clk_sel;
            rx_clk_prev_q <= ext_s;
        end
    end

    // Bit and slot counters, 32 slots of 8 bits form 256-bit frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 3'h0;
            slot_q <= 5'h00;
            nfas_q <= 1'b0;
        end else if (tx_edge) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == E1CF_BIT_LAST) begin
                slot_q <= slot_q + 5'h01;
                if (slot_q == E1CF_TS_LAST) begin
                    nfas_q <= !nfas_q;
                end
            end
        end
    end

    // Transmit bit register and data link tap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_bit_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            if (tx_edge) begin
                tx_bit_q <= line_bit;
                if (nfas_q && (slot_q == E1CF_TS_ALIGN) && (bit_q >= 3'h3)) begin
                    link_q <= line_bit;
                end
            end
        end
    end

    // Line coder, bit 5 picks HDB3 over AMI
    e1cf_hdb3 u_coder (
        .clk(clk),
        .rst_n(rst_n),
        .bit_en(tx_edge),
        .bit_in(tx_bit_q),
        .hdb3_en(ctrl_q[E1CF_CTRL_LINECODE]),
        .pos_q(pos_w),
        .neg_q(neg_w)
    );

    // Receive search for the alignment tail
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hist_q <= 7'h00;
            found_q <= 1'b0;
        end else if (rx_edge) begin
            rx_hist_q <= {rx_hist_q[5:0], rxd_s};
            found_q <= ({rx_hist_q[5:0], rxd_s} == E1CF_FAS_TAIL);
        end
    end

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= E1CF_CTRL_RST;
            ja_q <= E1CF_JA_RST;
            nat_q <= E1CF_NAT_RST;
        end else if (reg_wr) begin
            if (reg_addr == E1CF_REG_CTRL) begin
                ctrl_q <= reg_wdata;
            end else if (reg_addr == E1CF_REG_JA) begin
                ja_q <= reg_wdata;
            end else if (reg_addr == E1CF_REG_NAT) begin
                nat_q <= {3'h0, reg_wdata[4:0]};
            end
        end
    end

    // Read selection, unmapped reads zero
    assign rd_mux = (reg_addr == E1CF_REG_CTRL) ? ctrl_q :
                    (reg_addr == E1CF_REG_JA) ? ja_q :
                    (reg_addr == E1CF_REG_NAT) ? nat_q :
                    (reg_addr == E1CF_REG_STAT) ? {found_q, bus_mode, ja_tx, ja_rx, 1'b0, mode} :
                    (reg_addr == E1CF_REG_ID) ? E1CF_ID_VAL : 8'h00;

    // Read data one cycle after the strobe, held only there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // Registered pin and clock outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backplane_clock_out <= 1'b0;
            backplane_frame_pulse_out <= 1'b0;
            backplane_oe_n <= 1'b1;
            extracted_clock_out <= 1'b0;
            tx_clock_src <= 2'h0;
            ja_on_tx <= 1'b0;
            ja_on_rx <= 1'b0;
            depth_q <= 3'h7;
        end else begin
            backplane_oe_n <= bus_mode;
            backplane_clock_out <= (mode == E1CF_FREE_RUN) ? int_s : cln_s;
            backplane_frame_pulse_out <= (slot_q == E1CF_TS_ALIGN) && (bit_q == 3'h0);
            extracted_clock_out <= (mode == E1CF_BUS_SYNC_RX_ATTENUATED) ? cln_s : ext_s;
            tx_clock_src <= tx_src;
            ja_on_tx <= ja_tx;
            ja_on_rx <= ja_rx;
            depth_q <= depth_sel;
        end
    end
    assign tx_line_pos = pos_w;
    assign tx_line_neg = neg_w;
    assign link_data_out = link_q;
    assign frame_found = found_q;

    // Assertions
    a_free_run_off: assert property (@(posedge clk) disable iff (!rst_n)
        !bfr_s |=> !ja_on_tx && !ja_on_rx) else $error("attenuator on in free-run");
    a_line_rx_side: assert property (@(posedge clk) disable iff (!rst_n)
        bfr_s && !bsl_s |=> ja_on_rx && !ja_on_tx) else $error("line sync side wrong");
    a_tx_side_sel: assert property (@(posedge clk) disable iff (!rst_n)
        bfr_s && bsl_s && ja_q[E1CF_JA_EN] && ja_q[E1CF_JA_SIDE] |=> ja_on_tx && !ja_on_rx)
        else $error("tx side not chosen");
    a_rx_side_sel: assert property (@(posedge clk) disable iff (!rst_n)
        bfr_s && bsl_s && ja_q[E1CF_JA_EN] && !ja_q[E1CF_JA_SIDE] |=> ja_on_rx && !ja_on_tx)
        else $error("rx side not chosen");
    a_bypass_both: assert property (@(posedge clk) disable iff (!rst_n)
        bfr_s && bsl_s && !ja_q[E1CF_JA_EN] |=> !ja_on_rx && !ja_on_tx) else $error("bypass failed");
    a_pin_direction: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> backplane_oe_n == $past(bus_mode)) else $error("backplane direction wrong");
    a_frame_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        tx_edge && bit_q == E1CF_BIT_LAST && slot_q == E1CF_TS_LAST |=> nfas_q != $past(nfas_q))
        else $error("words not alternating");
    a_slot_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        tx_edge && bit_q == E1CF_BIT_LAST |=> slot_q == $past(slot_q) + 5'h01) else $error("slot count wrong");

    // Shared clock and reset for the checks below
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Frame steps: last bit of a frame
    sequence s_frame_end;
        tx_edge && bit_q == E1CF_BIT_LAST && slot_q == E1CF_TS_LAST;
    endsequence

    // Bit two of the slot 0 word
    sequence s_word_bit2;
        tx_edge && slot_q == E1CF_TS_ALIGN && bit_q == 3'h1;
    endsequence

    // Last spare bit of the non-alignment word
    sequence s_spare_last;
        tx_edge && nfas_q && slot_q == E1CF_TS_ALIGN && bit_q == E1CF_BIT_LAST;
    endsequence

    // Frame length and slot 0 content
    a_frame_wrap: assert property (s_frame_end |=> slot_q == E1CF_TS_ALIGN && bit_q == 3'h0)
        else $error("frame length wrong");

    a_word_bit2: assert property (s_word_bit2 |=> tx_bit_q == $past(nfas_q))
        else $error("slot 0 bit two wrong");

    a_spare_link: assert property (s_spare_last |=> link_q == $past(nat_q[0]))
        else $error("data link tap wrong");

    a_rai_bit3: assert property (tx_edge && nfas_q && slot_q == E1CF_TS_ALIGN && bit_q == 3'h2
        |=> tx_bit_q == $past(ctrl_q[E1CF_CTRL_RAI])) else $error("alarm bit wrong");

    a_fas_bit1: assert property (tx_edge && !nfas_q && slot_q == E1CF_TS_ALIGN && bit_q == 3'h0
        |=> tx_bit_q == $past(ctrl_q[E1CF_CTRL_SI_FAS])) else $error("alignment bit one wrong");

    a_nfas_bit1: assert property (tx_edge && nfas_q && slot_q == E1CF_TS_ALIGN && bit_q == 3'h0
        |=> tx_bit_q == $past(ctrl_q[E1CF_CTRL_SI_NFAS])) else $error("non-alignment bit one wrong");

    // Payload passes straight from the backplane
    a_payload_bit: assert property (tx_edge && slot_q != E1CF_TS_ALIGN |=> tx_bit_q == $past(bpd_s))
        else $error("payload bit wrong");

    // Receive search
    a_tail_found: assert property (rx_edge && {rx_hist_q[5:0], rxd_s} == E1CF_FAS_TAIL |=> found_q)
        else $error("alignment tail missed");

    // Clock routing per mode
    a_tx_dejitter: assert property (mode == E1CF_BUS_SYNC_TX_ATTENUATED
        |=> tx_clock_src == E1CF_SRC_CLEAN && extracted_clock_out == $past(ext_s)) else $error("mode one routing");

    a_rx_clean_out: assert property (mode == E1CF_BUS_SYNC_RX_ATTENUATED
        |=> tx_clock_src == E1CF_SRC_BACKPLANE && extracted_clock_out == $past(cln_s)) else $error("mode two routing");

    a_raw_out: assert property (mode == E1CF_BUS_SYNC_NO_ATTENUATION
        |=> tx_clock_src == E1CF_SRC_BACKPLANE && extracted_clock_out == $past(ext_s)) else $error("mode three routing");

    a_line_clean_src: assert property (bfr_s && !bsl_s
        |=> tx_clock_src == E1CF_SRC_CLEAN && backplane_clock_out == $past(cln_s)) else $error("line sync routing");

    a_free_internal: assert property (!bfr_s
        |=> tx_clock_src == E1CF_SRC_INTERNAL && backplane_clock_out == $past(int_s)) else $error("free-run routing");

    // Line coding: a mark is one pulse of one polarity
    a_ami_mark: assert property (tx_edge && tx_bit_q && !ctrl_q[E1CF_CTRL_LINECODE]
        |=> tx_line_pos != tx_line_neg) else $error("mark not coded");

    // Depth code follows the register
    a_depth_code: assert property ($past(rst_n) |-> depth_q == $past(depth_sel))
        else $error("depth code wrong");
endmodule

// *** verification/e1cf_line_model.sv ***
// Behavioural far-side model: recovered, clean, free-run and backplane clocks, receive bits
`timescale 1ns/1ns
module e1cf_line_model (
    output logic extracted_clock,
    output logic clean_clock,
    output logic internal_clock,
    output logic backplane_clock,
    output logic frame_pulse,
    output logic backplane_data,
    output logic rx_data
);
    localparam int HALF_NS = 24;
    // Quiet lines until the bench steers them
    initial begin
        extracted_clock = 1'b0;
        clean_clock = 1'b0;
        internal_clock = 1'b0;
        backplane_clock = 1'b0;
        frame_pulse = 1'b0;
        backplane_data = 1'b0;
        rx_data = 1'b0;
    end
    // Hold every clock still at chosen levels, off the system clock edge
    task automatic set_levels(input logic raw, input logic clean, input logic intl, input logic bp);
        #1;
        extracted_clock = raw;
        clean_clock = clean;
        internal_clock = intl;
        backplane_clock = bp;
    endtask
    // Backplane clock burst, stopped low between bursts
    task automatic clock_bp(input int n);
        for (int i = 0; i < n; i++) begin
            #HALF_NS;
            backplane_clock = 1'b1;
            #HALF_NS;
            backplane_clock = 1'b0;
        end
    endtask
    // Bits go out first bit first, data moves on falling edges, clock stops after the last bit
    task automatic send(input logic [15:0] bits, input int n);
        extracted_clock = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            rx_data = bits[i];
            #HALF_NS;
            extracted_clock = 1'b1;
            #HALF_NS;
            extracted_clock = 1'b0;
        end
        // Released line must not keep showing the last bit
        rx_data = ~rx_data;
    endtask
endmodule

// *** verification/e1cf_top_tb_top.sv ***
// Self-checking testbench for the E1 clock mode and frame format block
`timescale 1ns/1ns
module e1cf_top_tb_top
    import e1cf_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_or_line_sync_pin = 1'b1;
    logic locked_or_freerun_pin = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic bp_clk_in, bp_fp_in, bp_data_in, raw_clk, clean_clk, int_clk, rx_data;
    logic backplane_clock_out, backplane_frame_pulse_out, backplane_oe_n, extracted_clock_out;
    logic ja_on_tx, ja_on_rx, tx_line_pos, tx_line_neg, link_data_out, frame_found;
    logic [1:0] tx_clock_src;
    logic [7:0] d;
    logic [15:0] row;
    logic lv;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    // Mode table rows: pins, attenuator bits, then expected placement, oe_n, source, clean out, mode
    logic [15:0] rows [7] = '{16'hFA80, 16'hE641, 16'hD202, 16'hC202, 16'h7483, 16'h2184, 16'hB184};
    logic [3:0] reg_a [5] = '{E1CF_REG_CTRL, E1CF_REG_JA, E1CF_REG_NAT, E1CF_REG_ID, 4'h7};
    logic [7:0] reg_rst [5] = '{8'h20, 8'h70, 8'h1F, E1CF_ID_VAL, 8'h00};
    logic [7:0] reg_w [5] = '{8'h07, 8'h32, 8'h15, 8'h00, 8'hFF};
    logic [7:0] reg_back [5] = '{8'h07, 8'h32, 8'h15, E1CF_ID_VAL, 8'h00};

    e1cf_top uut (.clk(clk), .rst_n(rst_n), .bus_or_line_sync_pin(bus_or_line_sync_pin),
        .locked_or_freerun_pin(locked_or_freerun_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .backplane_clock_in(bp_clk_in),
        .backplane_frame_pulse_in(bp_fp_in), .backplane_clock_out(backplane_clock_out),
        .backplane_frame_pulse_out(backplane_frame_pulse_out), .backplane_oe_n(backplane_oe_n),
        .extracted_clock_in(raw_clk), .clean_clock_in(clean_clk), .internal_clock_in(int_clk),
        .extracted_clock_out(extracted_clock_out), .tx_clock_src(tx_clock_src), .ja_on_tx(ja_on_tx),
        .ja_on_rx(ja_on_rx), .backplane_data_in(bp_data_in), .rx_line_data(rx_data),
        .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .link_data_out(link_data_out),
        .frame_found(frame_found));

    e1cf_line_model model (.extracted_clock(raw_clk), .clean_clock(clean_clk), .internal_clock(int_clk),
        .backplane_clock(bp_clk_in), .frame_pulse(bp_fp_in), .backplane_data(bp_data_in), .rx_data(rx_data));

    // System clock, 4 ns period
    always #2 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("BAD %0t run did not finish in time", $time);
            summarize();
        end
    end

    // Compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Run n backplane clocks, then let the design settle
    task automatic tx_steps(input int n);
        model.clock_bp(n);
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Closing report
    task automatic summarize();
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (19) @(posedge clk);
        #1;
        chk({3'h0, backplane_oe_n, ja_on_tx, ja_on_rx, tx_clock_src}, 8'h10, "outputs in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset values, write and readback, unmapped place
        for (int i = 0; i < 5; i++) begin
            rd(reg_a[i], d);
            chk(d, reg_rst[i], "register reset value");
        end
        for (int i = 0; i < 5; i++) begin
            if (i != 3) begin
                wr(reg_a[i], reg_w[i]);
            end
            rd(reg_a[i], d);
            chk(d, reg_back[i], "register readback");
        end
        $display("test registers done");
        // Receive alignment search: near miss, then the true tail
        model.send(16'hFF9A, 16);
        repeat (10) @(posedge clk);
        #1;
        chk({7'h00, frame_found}, 8'h00, "near miss tail");
        model.send(16'hFF9B, 16);
        repeat (10) @(posedge clk);
        #1;
        chk({7'h00, frame_found}, 8'h01, "alignment tail");
        rd(E1CF_REG_STAT, d);
        chk({d[7], 7'h00}, 8'h80, "found in status");
        $display("test alignment done");
        // Frame build on the backplane clock, AMI, spare bits 10101, marks in slot 0
        chk({7'h00, backplane_frame_pulse_out}, 8'h01, "frame start pulse");
        tx_steps(256);
        chk({7'h00, backplane_frame_pulse_out}, 8'h01, "next frame pulse");
        tx_steps(5);
        chk({6'h00, tx_line_pos | tx_line_neg, link_data_out}, 8'h02, "spare bit four");
        tx_steps(1);
        chk({6'h00, tx_line_pos | tx_line_neg, link_data_out}, 8'h01, "spare bit five");
        tx_steps(2);
        chk({6'h00, tx_line_pos | tx_line_neg, link_data_out}, 8'h01, "spare bit eight");
        $display("test transmit done");
        // Every clock mode, with clock levels steered both ways
        for (int r = 0; r < 7; r++) begin
            row = rows[r];
            @(posedge clk);
            bus_or_line_sync_pin <= row[15];
            locked_or_freerun_pin <= row[14];
            wr(E1CF_REG_JA, {6'h1C, row[12], row[13]});
            repeat (8) @(posedge clk);
            #1;
            chk({5'h00, ja_on_tx, ja_on_rx, backplane_oe_n}, {5'h00, row[11:9]}, "placement");
            chk({6'h00, tx_clock_src}, {6'h00, row[8:7]}, "transmit source");
            rd(E1CF_REG_STAT, d);
            chk({1'b0, d[6:0]}, {1'b0, row[15] & row[14], row[11:10], 1'b0, row[2:0]}, "mode status");
            for (int s = 0; s < 2; s++) begin
                lv = s[0];
                model.set_levels(~lv, lv, ~lv, lv);
                repeat (8) @(posedge clk);
                #1;
                chk({7'h00, extracted_clock_out}, {7'h00, row[6] ? lv : ~lv}, "extracted out");
                if (!row[9]) begin
                    chk({7'h00, backplane_clock_out}, {7'h00, (row[2:0] == 3'h3) ? lv : ~lv}, "bp clock");
                end
            end
        end
        $display("test clock modes done");
        summarize();
    end
endmodule
